// [rtl/cmn_master_ctl.sv]
// CAN master network-management control, fault handling and registers
//
// Overview of operation
// - Bit-rate code maps to fixed rates
// - Command low byte selects network command
// - Toggle bit change sends the command
// - Bit 15 disables all communication
// - Bits 16-23 give destination node
// - Supply loss flagged, telegrams stop
// - Supply return restarts communication automatically
// - Excess errors enter bus-off, halt interface
// - Bus-off left only via supply cycle
// - Periodic error-control telegram exchange
// - Missing error-control telegram flags failure
// - Sent toggle copied to state bit 8
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ps
module cmn_master_ctl
  import cmn_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic [5:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic BUS_PWR,
  input wire logic ERR_EXCESS,
  input wire logic GUARD_RX,
  input wire logic NMT_DONE,
  output logic NMT_REQ,
  output logic [7:0] NMT_CODE,
  output logic [7:0] NMT_NODE,
  output logic GUARD_TX,
  output logic COMM_EN,
  output logic [7:0] NODE_ID,
  output logic NODE_ID_OK,
  output logic [9:0] BIT_RATE_KBPS,
  output logic STATUS_ERR,
  output logic IRQ
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed
  {
    logic [7:0] node;
    logic [7:0] rate;
    logic [31:0] cmd;
    logic [15:0] per;
    logic [15:0] tmo;
    logic tog_ref;
    logic tog_ack;
    logic ec_err;
    cmn_comm_type comm;
    logic nmt_req;
    logic [7:0] nmt_code;
    logic [7:0] nmt_node;
    logic nmt_tog;
    logic guard_tx;
    logic comm_en;
    logic node_ok;
    logic [9:0] kbps;
    logic status_err;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    logic [31:0] rdata;
  } cmn_state_type;

  cmn_state_type r;
  cmn_state_type n;
  logic active;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] clr;
  logic [15:0] state_word;

  cmn_grd_if grd ();

  // ****************************************************************
  // Error-control timer
  // ****************************************************************
  cmn_grd_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .grd(grd)
  );

  // Timer runs only while the link is up and a period is set
  assign grd.en = active && (r.per != 16'h0000);
  assign grd.period = r.per;
  assign grd.timeout = r.tmo;
  assign grd.rx_seen = GUARD_RX;

  // Link may carry telegrams
  assign active = (r.comm == CM_RUN) && !r.cmd[CMD_DIS];

  // Master state word as software reads it
  always_comb
  begin
    state_word = 16'h0000;
    state_word[ST_EC_INIT] = grd.en;
    state_word[ST_EC_ERR] = r.ec_err;
    state_word[ST_TOG] = r.tog_ack;
    state_word[ST_BUSOFF] = (r.comm == CM_BUSOFF);
    state_word[ST_NOPWR] = (r.comm == CM_NOPWR);
    state_word[ST_DIS] = r.cmd[CMD_DIS];
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    n = r;
    ev = '0;
    clr = '0;
    n.rdata = 32'h0000_0000;

    // Supply and bus-off sequencing
    case (r.comm)
      CM_OFF:
        n.comm = BUS_PWR ? CM_RUN : CM_NOPWR;
      CM_RUN:
      begin
        if (!BUS_PWR)
          n.comm = CM_NOPWR;
        else if (ERR_EXCESS)
          n.comm = CM_BUSOFF;
      end
      CM_BUSOFF:
      begin
        // only a supply cycle leaves bus-off
        if (!BUS_PWR)
          n.comm = CM_NOPWR;
      end
      CM_NOPWR:
      begin
        if (BUS_PWR)
          n.comm = CM_RUN;
      end
      default:
        n.comm = CM_OFF;
    endcase
    ev[IRQ_BUSOFF] = (r.comm == CM_RUN) && BUS_PWR && ERR_EXCESS;
    ev[IRQ_NOPWR] = (r.comm != CM_NOPWR) && !BUS_PWR;

    // Register writes
    if (WR)
    begin
      case (ADDR)
        OFS_NODE: n.node = WDATA[7:0];
        OFS_RATE: n.rate = WDATA[7:0];
        OFS_CMD: n.cmd = WDATA & CMD_MASK;
        OFS_GRD_PER: n.per = WDATA[15:0];
        OFS_GRD_TMO: n.tmo = WDATA[15:0];
        OFS_IRQ_MASK: n.irq_mask = WDATA[IRQ_W-1:0];
        OFS_IRQ_STAT: clr = WDATA[IRQ_W-1:0];
        default: ;
      endcase
    end

    // Network-management command handshake
    if (r.nmt_req)
    begin
      if (NMT_DONE)
      begin
        n.nmt_req = 1'b0;
        n.tog_ack = r.nmt_tog;
        ev[IRQ_NMT] = 1'b1;
      end
      else if (!active)
      begin
        n.nmt_req = 1'b0;
      end
    end
    // any toggle edge launches a command if its code is defined
    else if (active && (r.cmd[CMD_TOG] != r.tog_ref))
    begin
      n.tog_ref = r.cmd[CMD_TOG];
      // only defined command codes go out
      if (nmt_code_ok(r.cmd[7:0]))
      begin
        n.nmt_req = 1'b1;
        n.nmt_code = r.cmd[7:0];
        n.nmt_node = r.cmd[23:16];
        n.nmt_tog = r.cmd[CMD_TOG];
      end
    end

    n.guard_tx = grd.tx_req;
    // failure stays until the partner answers again or the timer stops
    if (grd.fail)
      n.ec_err = 1'b1;
    else if (GUARD_RX || !grd.en)
      n.ec_err = 1'b0;
    ev[IRQ_GUARD] = grd.fail;

    // Sticky status, set wins over clear
    n.irq_stat = (r.irq_stat & ~clr) | ev;
    n.irq = |(n.irq_stat & n.irq_mask);

    // disable bit drops the link enable
    n.comm_en = (n.comm == CM_RUN) && !n.cmd[CMD_DIS];
    // indicator for supply, bus-off and guard faults
    n.status_err = (n.comm == CM_NOPWR) || (n.comm == CM_BUSOFF) || n.ec_err;
    // flag a node address inside 1 to 127 as valid
    n.node_ok = (n.node >= NODE_MIN) && (n.node <= NODE_MAX);
    n.kbps = rate_kbps(n.rate);

    // Register reads, data valid in the next cycle only
    if (RD)
    begin
      case (ADDR)
        OFS_NODE: n.rdata = {24'h000000, r.node};
        OFS_RATE: n.rdata = {24'h000000, r.rate};
        OFS_CMD: n.rdata = r.cmd;
        OFS_STATE: n.rdata = {16'h0000, state_word};
        OFS_IRQ_STAT: n.rdata = {28'h0000000, r.irq_stat};
        OFS_IRQ_MASK: n.rdata = {28'h0000000, r.irq_mask};
        OFS_GRD_PER: n.rdata = {16'h0000, r.per};
        OFS_GRD_TMO: n.rdata = {16'h0000, r.tmo};
        default: n.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      // toggle reference equals reset command bit
      r <= '0;
      r.node <= RST_NODE;
      r.rate <= RST_RATE;
      r.cmd <= RST_CMD;
      r.tog_ref <= RST_CMD[CMD_TOG];
      r.per <= RST_GRD;
      r.tmo <= RST_GRD;
      r.irq_stat <= RST_IRQ;
      r.irq_mask <= RST_IRQ;
      r.comm <= CM_OFF;
    end
    else
    begin
      r <= n;
    end
  end

  // Outputs straight from flip-flops
  assign RDATA = r.rdata;
  assign NMT_REQ = r.nmt_req;
  assign NMT_CODE = r.nmt_code;
  assign NMT_NODE = r.nmt_node;
  assign GUARD_TX = r.guard_tx;
  assign COMM_EN = r.comm_en;
  assign NODE_ID = r.node;
  assign NODE_ID_OK = r.node_ok;
  assign BIT_RATE_KBPS = r.kbps;
  assign STATUS_ERR = r.status_err;
  assign IRQ = r.irq;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_rate_map: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (RST_N && !WR) |=> BIT_RATE_KBPS == rate_kbps($past(r.rate)))
    else $error("bit rate does not follow code");

  a_nmt_code: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    NMT_REQ |-> nmt_code_ok(NMT_CODE))
    else $error("undefined command code sent");

  a_tog_cause: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    $rose(NMT_REQ) |-> $past(r.cmd[CMD_TOG]) != $past(r.tog_ref))
    else $error("command sent without toggle change");

  a_dis_stop: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (r.cmd[CMD_DIS] && !WR) |=> !COMM_EN ##1 !NMT_REQ)
    else $error("link enabled while disabled");

  a_dest_node: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    $rose(NMT_REQ) |-> NMT_NODE == $past(r.cmd[23:16]) && NMT_CODE == $past(r.cmd[7:0]))
    else $error("command target mismatch");

  a_nopwr_flag: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    !BUS_PWR |=> !COMM_EN && STATUS_ERR)
    else $error("supply loss not handled");

  a_pwr_restart: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (r.comm == CM_NOPWR && BUS_PWR) |=> r.comm == CM_RUN)
    else $error("no restart after supply return");

  a_busoff_enter: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (r.comm == CM_RUN && BUS_PWR && ERR_EXCESS) |=> !COMM_EN && STATUS_ERR)
    else $error("bus-off not entered");

  a_busoff_hold: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (r.comm == CM_BUSOFF && BUS_PWR) |=> r.comm == CM_BUSOFF)
    else $error("bus-off left without supply cycle");

  a_guard_fail: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    grd.fail |=> r.ec_err && STATUS_ERR && r.irq_stat[IRQ_GUARD])
    else $error("guard failure not reported");

  a_ack_copy: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (NMT_REQ && NMT_DONE) |=> !NMT_REQ && r.tog_ack == $past(r.nmt_tog))
    else $error("toggle acknowledge wrong");

  a_rsv_drop: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (WR && ADDR == OFS_CMD) |=> (r.cmd & ~CMD_MASK) == 32'h0000_0000)
    else $error("reserved command bits stored");

endmodule // cmn_master_ctl

// [inc/cmn_pkg.sv]
// Package for the CAN master network-management control block
package cmn_pkg;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [5:0] OFS_NODE = 6'h00;
  localparam logic [5:0] OFS_RSV_A = 6'h04;
  localparam logic [5:0] OFS_RSV_B = 6'h08;
  localparam logic [5:0] OFS_RATE = 6'h0C;
  localparam logic [5:0] OFS_CMD = 6'h10;
  localparam logic [5:0] OFS_STATE = 6'h14;
  localparam logic [5:0] OFS_IRQ_STAT = 6'h18;
  localparam logic [5:0] OFS_IRQ_MASK = 6'h1C;
  localparam logic [5:0] OFS_GRD_PER = 6'h20;
  localparam logic [5:0] OFS_GRD_TMO = 6'h24;

  // ****************************************************************
  // Field positions and masks
  // ****************************************************************
  localparam int CMD_TOG = 8;
  localparam int CMD_DIS = 15;
  localparam logic [31:0] CMD_MASK = 32'h00FF_81FF;
  localparam int ST_EC_INIT = 2;
  localparam int ST_EC_ERR = 5;
  localparam int ST_TOG = 8;
  localparam int ST_BUSOFF = 13;
  localparam int ST_NOPWR = 14;
  localparam int ST_DIS = 15;
  localparam int IRQ_NMT = 0;
  localparam int IRQ_BUSOFF = 1;
  localparam int IRQ_NOPWR = 2;
  localparam int IRQ_GUARD = 3;
  localparam int IRQ_W = 4;

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam logic [7:0] RST_NODE = 8'h00;
  localparam logic [7:0] RST_RATE = 8'h00;
  localparam logic [31:0] RST_CMD = 32'h0000_0000;
  localparam logic [15:0] RST_GRD = 16'h0000;
  localparam logic [IRQ_W-1:0] RST_IRQ = 4'h0;

  // ****************************************************************
  // Codes and limits
  // ****************************************************************
  localparam logic [7:0] NODE_MIN = 8'h01;
  localparam logic [7:0] NODE_MAX = 8'h7F;
  localparam logic [7:0] NMT_START = 8'h01;
  localparam logic [7:0] NMT_STOP = 8'h02;
  localparam logic [7:0] NMT_PREOP = 8'h80;
  localparam logic [7:0] NMT_RST_NODE = 8'h81;
  localparam logic [7:0] NMT_RST_COMM = 8'h82;

  // ****************************************************************
  // Timing: error-control intervals count in 1 ms ticks
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Link state, Gray order along off, run, bus-off
  typedef enum logic [1:0]
  {
    CM_OFF = 2'b00,
    CM_RUN = 2'b01,
    CM_BUSOFF = 2'b11,
    CM_NOPWR = 2'b10
  } cmn_comm_type;

  // Bit-rate code to kbit/s, zero for reserved codes
  function automatic logic [9:0] rate_kbps(input logic [7:0] code);
    case (code)
      8'h00: rate_kbps = 10'h3E8;
      8'h02: rate_kbps = 10'h1F4;
      8'h03: rate_kbps = 10'h0FA;
      8'h04: rate_kbps = 10'h07D;
      8'h05: rate_kbps = 10'h064;
      8'h06: rate_kbps = 10'h032;
      8'h07: rate_kbps = 10'h014;
      default: rate_kbps = 10'h000;
    endcase
  endfunction

  // True for the five network-management command codes
  function automatic logic nmt_code_ok(input logic [7:0] code);
    nmt_code_ok = (code == NMT_START) || (code == NMT_STOP) || (code == NMT_PREOP) ||
      (code == NMT_RST_NODE) || (code == NMT_RST_COMM);
  endfunction

endpackage

// [inc/cmn_grd_if.sv]
// Interface between link control and the error-control timer
`timescale 1ns/1ps
interface cmn_grd_if;
  logic en;
  logic [15:0] period;
  logic [15:0] timeout;
  logic rx_seen;
  logic tx_req;
  logic fail;

  modport ctl
  (
    output en, period, timeout, rx_seen,
    input tx_req, fail
  );

  modport tmr
  (
    input en, period, timeout, rx_seen,
    output tx_req, fail
  );
endinterface

// [rtl/cmn_grd_timer.sv]
// Error-control timer: periodic telegram request and receive timeout
`timescale 1ns/1ps
module cmn_grd_timer
  import cmn_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)
(
  input wire logic clk,
  input wire logic rst_n,
  cmn_grd_if.tmr grd
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed
  {
    logic [23:0] pre_cnt;
    logic [15:0] per_cnt;
    logic [15:0] tmo_cnt;
    logic tx_req;
    logic fail;
    logic failed;
  } cmn_tmr_type;

  cmn_tmr_type r;
  cmn_tmr_type n;
  logic tick;

  // Refuse prescaler counts the counter cannot hold
  if (TICK_CYCLES < 1 || TICK_CYCLES > 16777215)
  begin : g_bad_tick
    $error("TICK_CYCLES out of range");
  end

  // Next state
  always_comb
  begin
    n = r;
    n.tx_req = 1'b0;
    n.fail = 1'b0;
    tick = (r.pre_cnt == 24'(TICK_CYCLES - 1));
    if (!grd.en)
    begin
      n = '0;
    end
    else
    begin
      n.pre_cnt = tick ? 24'h000000 : r.pre_cnt + 24'h000001;
      if (tick && grd.period != 16'h0000)
      begin
        if (r.per_cnt + 16'h0001 >= grd.period)
        begin
          n.per_cnt = 16'h0000;
          n.tx_req = 1'b1;
        end
        else
        begin
          n.per_cnt = r.per_cnt + 16'h0001;
        end
      end
      if (grd.rx_seen)
      begin
        n.tmo_cnt = 16'h0000;
        n.failed = 1'b0;
      end
      else if (tick && !r.failed && grd.timeout != 16'h0000)
      begin
        n.tmo_cnt = r.tmo_cnt + 16'h0001;
        if (r.tmo_cnt + 16'h0001 >= grd.timeout)
        begin
          n.fail = 1'b1;
          n.failed = 1'b1;
        end
      end
    end
  end

  // Registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      r <= '0;
    else
      r <= n;
  end

  assign grd.tx_req = r.tx_req;
  assign grd.fail = r.fail;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_fail_once: assert property (@(posedge clk) disable iff (!rst_n)
    r.fail |=> !r.fail [*2])
    else $error("timeout reported twice in a row");

endmodule // cmn_grd_timer

// [testbench/cmn_slave_model.sv]
// Model of the CAN engine and the slave nodes beside the master control block
`timescale 1ns/1ps
module cmn_slave_model
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic nmt_req,
  input wire logic guard_tx,
  input wire logic slow,
  input wire logic silent,
  output logic nmt_done,
  output logic guard_rx
);
  // Acknowledge a pending command after a short or a long send time
  initial
  begin
    nmt_done = 1'b0;
    forever
    begin
      @(posedge clk);
      if (rst_n && nmt_req)
      begin
        repeat (slow ? 6 : 0) @(posedge clk);
        nmt_done <= 1'b1;
        @(posedge clk);
        nmt_done <= 1'b0;
        @(posedge clk);
      end
    end
  end

  always @(posedge clk)
  begin
    guard_rx <= rst_n && guard_tx && !silent; // A silent node lets the timeout run
  end
endmodule // cmn_slave_model

// [testbench/can_master_nmt_control_tb.sv]
// Self-checking bench for the CAN master network-management control block
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
  $display("[FAIL] %0t got %h expected %h", $time, (a), (b)); end end
module can_master_nmt_control_tb
  import cmn_pkg::*;
;
  logic sys_clk, rst_n, wr, rd, bus_pwr, err_excess, guard_rx, nmt_done;
  logic nmt_req, guard_tx, comm_en, node_id_ok, status_err, irq, slow, silent, tog;
  logic [5:0] addr;
  logic [31:0] wdata, rdata, st, cmd_w;
  logic [7:0] nmt_code, nmt_node, node_id, node;
  logic [9:0] bit_rate_kbps;
  logic [15:0] lfsr_r;
  logic [7:0] codes [5] = '{8'h01, 8'h02, 8'h80, 8'h81, 8'h82};
  logic [7:0] nodes [5] = '{8'h00, 8'h01, 8'h7F, 8'h80, 8'hFF};
  int fails, n_compared, cnt;

  cmn_master_ctl #(.TICK_CYCLES(4)) i_cmn_master_ctl (.SYS_CLK(sys_clk), .RST_N(rst_n),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .BUS_PWR(bus_pwr),
    .ERR_EXCESS(err_excess), .GUARD_RX(guard_rx), .NMT_DONE(nmt_done), .NMT_REQ(nmt_req),
    .NMT_CODE(nmt_code), .NMT_NODE(nmt_node), .GUARD_TX(guard_tx), .COMM_EN(comm_en),
    .NODE_ID(node_id), .NODE_ID_OK(node_id_ok), .BIT_RATE_KBPS(bit_rate_kbps),
    .STATUS_ERR(status_err), .IRQ(irq));

  cmn_slave_model i_cmn_slave_model (.clk(sys_clk), .rst_n(rst_n), .nmt_req(nmt_req),
    .guard_tx(guard_tx), .slow(slow), .silent(silent), .nmt_done(nmt_done),
    .guard_rx(guard_rx));

  // Next value of the random source
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Expected rate for a bit-rate code
  function automatic logic [9:0] exp_rate(input logic [7:0] c);
    case (c)
      8'h00: exp_rate = 10'h3E8;
      8'h02: exp_rate = 10'h1F4;
      8'h03: exp_rate = 10'h0FA;
      8'h04: exp_rate = 10'h07D;
      8'h05: exp_rate = 10'h064;
      8'h06: exp_rate = 10'h032;
      8'h07: exp_rate = 10'h014;
      default: exp_rate = 10'h000;
    endcase
  endfunction

  // Verdict and end of run
  task automatic final_report();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Wait n edges, then settle at the falling edge
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  // One-cycle register write
  task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  // One-cycle register read, data taken in the following cycle
  task automatic rd_reg(input logic [5:0] a);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(negedge sys_clk);
    st = rdata;
  endtask

  // Read and compare a whole register
  task automatic chk_reg(input logic [5:0] a, input logic [31:0] e);
    rd_reg(a);
    `CHK(st, e)
  endtask

  // Bounded wait for the command request level
  task automatic wait_req(input logic lvl);
    for (int i = 0; i < 40 && nmt_req !== lvl; i++) @(negedge sys_clk);
    if (nmt_req !== lvl)
    begin
      fails++;
      final_report();
    end
  endtask

  // Command write with flipped toggle and random reserved bits
  task automatic send(input logic [7:0] code, input logic [7:0] nd, input logic dis);
    lfsr_r = lfsr_next(lfsr_r);
    tog = ~tog;
    cmd_w = {lfsr_r[7:0], nd, dis, lfsr_r[13:8], tog, code};
    wr_reg(OFS_CMD, cmd_w);
  endtask

  // Bench clock
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Main sequence
  initial
  begin
    {rst_n, wr, rd, err_excess, slow, silent, tog} = '0;
    {addr, wdata} = '0;
    bus_pwr = 1'b1;
    lfsr_r = 16'h0060;
    fails = 0;
    n_compared = 0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    cyc(3);
    `CHK(nmt_req, 1'b0)
    `CHK(comm_en, 1'b1)
    chk_reg(OFS_CMD, 32'h0000_0000);
    chk_reg(6'h3C, 32'h0000_0000);
    chk_reg(OFS_RSV_A, 32'h0000_0000);
    for (int c = 0; c < 9; c++)
    begin
      wr_reg(OFS_RATE, 32'(c));
      cyc(2);
      `CHK(bit_rate_kbps, exp_rate(8'(c)))
    end
    for (int i = 0; i < 6; i++)
    begin
      lfsr_r = lfsr_next(lfsr_r);
      node = (i < 5) ? nodes[i] : lfsr_r[7:0];
      wr_reg(OFS_NODE, {24'h000000, node});
      cyc(2);
      `CHK(node_id_ok, (node >= 8'h01 && node <= 8'h7F))
      `CHK(node_id, node)
    end
    for (int i = 0; i < 5; i++)
    begin
      slow = i[0];
      lfsr_r = lfsr_next(lfsr_r);
      node = {1'b0, lfsr_r[6:0]};
      send(codes[i], node, 1'b0);
      wait_req(1'b1);
      `CHK(nmt_code, codes[i])
      `CHK(nmt_node, node)
      chk_reg(OFS_CMD, cmd_w & CMD_MASK);
      wait_req(1'b0);
      rd_reg(OFS_STATE);
      `CHK(st[ST_TOG], tog)
    end
    send(8'h03, 8'h05, 1'b0);
    cyc(10);
    `CHK(nmt_req, 1'b0)
    rd_reg(OFS_STATE);
    `CHK(st[ST_TOG], ~tog)
    rd_reg(OFS_IRQ_STAT);
    `CHK(st[IRQ_NMT], 1'b1)
    `CHK(irq, 1'b0)
    wr_reg(OFS_IRQ_MASK, 32'h0000_000F);
    cyc(2);
    `CHK(irq, 1'b1)
    wr_reg(OFS_IRQ_STAT, 32'h0000_0001);
    cyc(2);
    `CHK(irq, 1'b0)
    send(NMT_START, 8'h09, 1'b1);
    cyc(3);
    `CHK(comm_en, 1'b0)
    `CHK(nmt_req, 1'b0)
    rd_reg(OFS_STATE);
    `CHK(st[ST_DIS], 1'b1)
    wr_reg(OFS_CMD, cmd_w & ~(32'h0000_0001 << CMD_DIS));
    wait_req(1'b1);
    `CHK(nmt_node, 8'h09)
    wait_req(1'b0);
    @(posedge sys_clk) err_excess <= 1'b1;
    cyc(3);
    `CHK(comm_en, 1'b0)
    `CHK(status_err, 1'b1)
    @(posedge sys_clk) err_excess <= 1'b0;
    cyc(5);
    rd_reg(OFS_STATE);
    `CHK(st[ST_BUSOFF], 1'b1)
    `CHK(comm_en, 1'b0)
    @(posedge sys_clk) bus_pwr <= 1'b0;
    cyc(3);
    rd_reg(OFS_STATE);
    `CHK(st[ST_NOPWR], 1'b1)
    `CHK(status_err, 1'b1)
    @(posedge sys_clk) bus_pwr <= 1'b1;
    cyc(3);
    `CHK(comm_en, 1'b1)
    `CHK(status_err, 1'b0)
    rd_reg(OFS_IRQ_STAT);
    `CHK(st[IRQ_NOPWR:IRQ_BUSOFF], 2'b11)
    wr_reg(OFS_GRD_PER, 32'h0000_0001);
    wr_reg(OFS_GRD_TMO, 32'h0000_0003);
    cnt = 0;
    for (int i = 0; i < 40; i++)
    begin
      @(negedge sys_clk);
      cnt += int'(guard_tx);
    end
    `CHK(cnt inside {[9:11]}, 1'b1)
    `CHK(status_err, 1'b0)
    @(posedge sys_clk) silent <= 1'b1;
    cyc(30);
    `CHK(status_err, 1'b1)
    rd_reg(OFS_STATE);
    `CHK(st[ST_EC_ERR], 1'b1)
    `CHK(st[ST_EC_INIT], 1'b1)
    @(posedge sys_clk) silent <= 1'b0;
    cyc(20);
    `CHK(status_err, 1'b0)
    final_report();
  end
endmodule // can_master_nmt_control_tb
